// ===== design/escl_loader.sv
// Purpose: reads page 0 and copies stored register images into the live map
// Assumes: nv array answers in the cycle that nv_rd_en stands
// Notes: live map is 128 bytes, readable and writable over apb
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "escl_defines.svh"
module escl_loader #(
  parameter int LIVE_BYTES = 128,
  parameter int NV_AW = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NV_AW-1:0] nv_addr,
  output logic nv_rd_en,
  output logic nv_wr_en,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata,
  input wire logic iface_pin_a,
  input wire logic iface_pin_c,
  input wire logic [1:0] host_pin_sel,
  output logic [2:0] host_iface_sel,
  output logic host_iface_en,
  output logic [6:0] i2c_slave_addr,
  output logic i2c_speed_variant_sel,
  output logic bscan_en,
  output logic [6:0] secure_module_addr,
  output logic load_done
);
  // whole module state, registered in one place
  typedef struct packed {
    escl_pkg::escl_state_t st;
    logic [7:0] cnt; // bytes copied in the current sequence
    logic rd_pend; // a read is in flight to the nv array
    logic [NV_AW-1:0] src; // current source address
    logic [7:0] dst; // current live byte index
    logic [7:0] i2c_addr;
    logic [7:0] iface;
    logic [7:0] sm_addr;
    logic [7:0] def_rx;
    logic [7:0] def_tx;
    logic [15:0] tx_crc;
    logic [15:0] rx_crc;
    logic [23:0] product;
    logic [7:0] version;
    logic [NV_AW-1:0] reset_base; // user-changeable reset image base
    logic [NV_AW-1:0] nv_ptr; // software access pointer into nv
    logic [7:0] nv_rbuf;
    logic nv_err; // refused write to read-only locations
    logic [7:0] prot_sel;
    logic [LIVE_BYTES*8-1:0] live;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NV_AW-1:0] nv_addr;
    logic nv_rd_en;
    logic nv_wr_en;
    logic [7:0] nv_wdata;
    logic [2:0] host_sel;
    logic host_en;
    logic [6:0] i2c_out;
    logic hsp;
    logic bscan;
    logic [6:0] sm_out;
    logic done;
  } escl_state_s_t;

  escl_state_s_t s;
  escl_state_s_t next_s;

  // apb address inside the live window; paddr[11:10] must be 01 so that
  // addresses above the window do not alias back onto live bytes
  function automatic logic in_live(input logic [11:0] a);
    return a[11:10] == 2'b01 && {1'b0, a[9:2]} < 9'(LIVE_BYTES);
  endfunction

  // live byte index from an apb address in the live window
  function automatic logic [7:0] live_idx(input logic [11:0] a);
    return a[9:2];
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic [7:0] li;

  // next-state logic
  always_comb begin
    next_s = s;
    // the registered pready pulse keeps one access from being taken twice
    acc = psel && penable && !s.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    li = live_idx(paddr);
    next_s.pready = acc;
    next_s.pslverr = 1'b0;
    next_s.nv_rd_en = 1'b0;
    next_s.nv_wr_en = 1'b0;
    next_s.rd_pend = 1'b0;
    unique case (s.st)
      escl_pkg::ESCL_CFG_READ: begin
        if (s.rd_pend) begin
          unique case (s.src)
            13'h0000: next_s.product[23:16] = nv_rdata;
            13'h0001: next_s.product[15:8] = nv_rdata;
            13'h0002: next_s.product[7:0] = nv_rdata;
            `ESCL_NV_VERSION: next_s.version = nv_rdata;
            `ESCL_NV_I2C_ADDR: next_s.i2c_addr = nv_rdata;
            `ESCL_NV_IFACE: next_s.iface = nv_rdata;
            `ESCL_NV_SM_ADDR: next_s.sm_addr = nv_rdata;
            `ESCL_NV_DEF_RX: next_s.def_rx = nv_rdata;
            `ESCL_NV_DEF_TX: next_s.def_tx = nv_rdata;
            13'h0026: next_s.tx_crc[15:8] = nv_rdata;
            13'h0027: next_s.tx_crc[7:0] = nv_rdata;
            13'h0028: next_s.rx_crc[15:8] = nv_rdata;
            13'h0029: next_s.rx_crc[7:0] = nv_rdata;
            default: next_s.version = s.version;
          endcase
          if (s.src == `ESCL_NV_VERSION) begin
            next_s.src = `ESCL_NV_I2C_ADDR;
          end else if (s.src == 13'h0029) begin
            next_s.st = escl_pkg::ESCL_RESET_COPY;
            next_s.src = s.reset_base;
            next_s.dst = 8'h00;
            next_s.cnt = 8'h00;
          end else begin
            next_s.src = s.src + 13'h0001;
          end
        end else begin
          next_s.nv_addr = s.src;
          next_s.nv_rd_en = 1'b1;
          next_s.rd_pend = 1'b1;
        end
      end
      escl_pkg::ESCL_RESET_COPY, escl_pkg::ESCL_PROT_COPY: begin
        if (s.rd_pend) begin
          next_s.live[s.dst*8 +: 8] = nv_rdata;
          next_s.src = s.src + 13'h0001;
          next_s.dst = s.dst + 8'h01;
          next_s.cnt = s.cnt + 8'h01;
          if (s.st == escl_pkg::ESCL_PROT_COPY && s.cnt == `ESCL_PROT_TX_BYTES - 8'h01) begin
            next_s.dst = `ESCL_PROT_TX_BYTES + 8'h40;
          end
          if ((s.st == escl_pkg::ESCL_RESET_COPY && s.cnt == `ESCL_RESET_BYTES - 8'h01) ||
              (s.st == escl_pkg::ESCL_PROT_COPY &&
               s.cnt == `ESCL_PROT_TX_BYTES + `ESCL_PROT_RX_BYTES - 8'h01)) begin
            next_s.st = escl_pkg::ESCL_IDLE;
            next_s.done = 1'b1;
          end
        end else begin
          next_s.nv_addr = s.src;
          next_s.nv_rd_en = 1'b1;
          next_s.rd_pend = 1'b1;
        end
      end
      // one quiet cycle after a write keeps the strobe a single pulse
      escl_pkg::ESCL_NV_WRITE: begin
        next_s.st = escl_pkg::ESCL_IDLE;
      end
      escl_pkg::ESCL_IDLE: begin
        // a pointer write fetched this byte
        if (s.rd_pend) begin
          next_s.nv_rbuf = nv_rdata;
        end
      end
    endcase
    // software accesses; live and config writes only while idle
    if (wr && s.st == escl_pkg::ESCL_IDLE) begin
      if (in_live(paddr)) begin
        next_s.live[li*8 +: 8] = pwdata[7:0];
      end else begin
        unique case (paddr)
          `ESCL_REG_I2C_ADDR: next_s.i2c_addr = pwdata[7:0];
          `ESCL_REG_IFACE: next_s.iface = pwdata[7:0];
          `ESCL_REG_SM_ADDR: next_s.sm_addr = pwdata[7:0];
          `ESCL_REG_DEF_RX: next_s.def_rx = pwdata[7:0];
          `ESCL_REG_DEF_TX: next_s.def_tx = pwdata[7:0];
          `ESCL_REG_TXCRC: next_s.tx_crc = pwdata[15:0];
          `ESCL_REG_RXCRC: next_s.rx_crc = pwdata[15:0];
          `ESCL_REG_RESET_BASE: next_s.reset_base = pwdata[NV_AW-1:0];
          `ESCL_REG_NV_PTR: begin
            next_s.nv_ptr = pwdata[NV_AW-1:0];
            next_s.nv_addr = pwdata[NV_AW-1:0];
            next_s.nv_rd_en = 1'b1;
            next_s.rd_pend = 1'b1;
          end
          `ESCL_REG_NV_DATA: begin
            // locations 0..31 refuse writes
            // the protocol area is read-only too; both report on pslverr
            if (s.nv_ptr <= `ESCL_NV_RO_LAST || s.nv_ptr >= `ESCL_NV_PROT_BASE) begin
              next_s.nv_err = 1'b1;
              next_s.pslverr = 1'b1;
            end else begin
              next_s.nv_addr = s.nv_ptr;
              next_s.nv_wdata = pwdata[7:0];
              next_s.nv_wr_en = 1'b1;
              next_s.st = escl_pkg::ESCL_NV_WRITE;
            end
          end
          `ESCL_REG_CTRL: begin
            if (pwdata[0]) begin
              next_s.prot_sel = pwdata[15:8];
              // entry numbers past the area wrap; software keeps to valid ones
              next_s.src = `ESCL_NV_PROT_BASE + 13'(pwdata[15:8]) * `ESCL_PROT_ENTRY;
              next_s.dst = 8'h40;
              next_s.cnt = 8'h00;
              next_s.done = 1'b0;
              next_s.st = escl_pkg::ESCL_PROT_COPY;
            end
            if (pwdata[1]) begin
              next_s.nv_err = 1'b0;
            end
            // rerun the reset copy from the user base
            if (pwdata[2]) begin
              next_s.src = s.reset_base;
              next_s.dst = 8'h00;
              next_s.cnt = 8'h00;
              next_s.done = 1'b0;
              next_s.st = escl_pkg::ESCL_RESET_COPY;
            end
          end
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end else if (wr) begin
      next_s.pslverr = 1'b1;
    end
    // read data
    if (rd) begin
      next_s.prdata = 32'h0000_0000;
      if (in_live(paddr)) begin
        next_s.prdata[7:0] = s.live[li*8 +: 8];
      end else begin
        unique case (paddr)
          `ESCL_REG_I2C_ADDR: next_s.prdata[7:0] = s.i2c_addr;
          `ESCL_REG_IFACE: next_s.prdata[7:0] = s.iface;
          `ESCL_REG_SM_ADDR: next_s.prdata[7:0] = s.sm_addr;
          `ESCL_REG_DEF_RX: next_s.prdata[7:0] = s.def_rx;
          `ESCL_REG_DEF_TX: next_s.prdata[7:0] = s.def_tx;
          `ESCL_REG_TXCRC: next_s.prdata[15:0] = s.tx_crc;
          `ESCL_REG_RXCRC: next_s.prdata[15:0] = s.rx_crc;
          `ESCL_REG_RESET_BASE: next_s.prdata[NV_AW-1:0] = s.reset_base;
          `ESCL_REG_NV_PTR: next_s.prdata[NV_AW-1:0] = s.nv_ptr;
          `ESCL_REG_NV_DATA: next_s.prdata[7:0] = s.nv_rbuf;
          `ESCL_REG_CTRL: next_s.prdata[15:8] = s.prot_sel;
          `ESCL_REG_STATUS: next_s.prdata = {27'h0, s.nv_err, s.st != escl_pkg::ESCL_IDLE,
                                              s.host_en, s.bscan, s.done};
          `ESCL_REG_PRODUCT: next_s.prdata = {s.product, s.version};
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end
    if (s.iface[`ESCL_IF_HOST_MSB]) begin
      next_s.host_sel = {1'b0, host_pin_sel};
    end else begin
      next_s.host_sel = s.iface[2:0];
    end
    if (s.iface[`ESCL_IF_ADDR_SRC_BIT]) begin
      next_s.i2c_out = s.i2c_addr[6:0];
    end else begin
      next_s.i2c_out = {`ESCL_I2C_PREFIX, iface_pin_c, iface_pin_a};
    end
    next_s.hsp = s.iface[`ESCL_IF_HSP_BIT];
    next_s.bscan = !s.iface[`ESCL_IF_BSCAN_BIT];
    next_s.sm_out = s.sm_addr[6:0];
    // enable only after loading; once on it stays on, so a later
    // protocol load does not cut off the host that asked for it
    next_s.host_en = s.host_en || (s.done && next_s.done);
  end

  // state register; factory images preload the live map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= escl_pkg::ESCL_CFG_READ;
      s.reset_base <= `ESCL_NV_RESET_BASE;
      s.iface <= 8'h80;
      s.hsp <= 1'b1;
      s.bscan <= 1'b1;
      // the copy overwrites these; they cover reads made before it ends
      // factory command and fifo values
      s.live[7:0] <= `ESCL_RST_COMMAND;
      s.live[23:16] <= `ESCL_RST_FIFO_CTRL;
      s.live[31:24] <= `ESCL_RST_FIFO_LEVEL;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign nv_addr = s.nv_addr;
  assign nv_rd_en = s.nv_rd_en;
  assign nv_wr_en = s.nv_wr_en;
  assign nv_wdata = s.nv_wdata;
  assign host_iface_sel = s.host_sel;
  assign host_iface_en = s.host_en;
  assign i2c_slave_addr = s.i2c_out;
  assign i2c_speed_variant_sel = s.hsp;
  assign bscan_en = s.bscan;
  assign secure_module_addr = s.sm_out;
  assign load_done = s.done;
endmodule
`default_nettype wire

// ===== design/escl_defines.svh
// Purpose: offsets, field positions and reset values of the startup configuration loader
// Assumes: byte-wide non-volatile array, apb word registers
// Notes: definitions only
`ifndef ESCL_DEFINES_SVH
`define ESCL_DEFINES_SVH
// non-volatile layout: page 0 fields, reset image base and protocol area base
`define ESCL_NV_RO_LAST 13'h001f
`define ESCL_NV_PAGE0_LAST 13'h003f
`define ESCL_NV_I2C_ADDR 13'h0020
`define ESCL_NV_IFACE 13'h0021
`define ESCL_NV_SM_ADDR 13'h0022
`define ESCL_NV_DEF_RX 13'h0023
`define ESCL_NV_DEF_TX 13'h0024
`define ESCL_NV_TXCRC 13'h0026
`define ESCL_NV_RXCRC 13'h0028
`define ESCL_NV_PROD_ID 13'h0000
`define ESCL_NV_VERSION 13'h0003
`define ESCL_NV_RESET_BASE 13'h0040
`define ESCL_NV_PROT_BASE 13'h1c00
// interface byte fields
`define ESCL_IF_HSP_BIT 7
`define ESCL_IF_ADDR_SRC_BIT 4
`define ESCL_IF_BSCAN_BIT 3
`define ESCL_IF_HOST_MSB 2
`define ESCL_I2C_PREFIX 5'h15
// copy sizes
`define ESCL_RESET_BYTES 8'h80
`define ESCL_PROT_TX_BYTES 8'h10
`define ESCL_PROT_RX_BYTES 8'h08
`define ESCL_PROT_ENTRY 13'h0018
// factory images that the loader must honour
`define ESCL_RST_COMMAND 8'h40
`define ESCL_RST_FIFO_CTRL 8'h80
`define ESCL_RST_FIFO_LEVEL 8'h05
// page offsets of the stored bytes double as register indices
`define ESCL_IDX_I2C_ADDR 12'h020
`define ESCL_IDX_IFACE 12'h021
`define ESCL_IDX_RXCRC 12'h028
// apb register byte addresses; one aligned word per register
`define ESCL_REG_I2C_ADDR (`ESCL_IDX_I2C_ADDR << 2)
`define ESCL_REG_IFACE (`ESCL_IDX_IFACE << 2)
`define ESCL_REG_RXCRC (`ESCL_IDX_RXCRC << 2)
`define ESCL_REG_SM_ADDR 12'h040
`define ESCL_REG_DEF_RX 12'h044
`define ESCL_REG_DEF_TX 12'h048
`define ESCL_REG_TXCRC 12'h04c
`define ESCL_REG_CTRL 12'h050
`define ESCL_REG_STATUS 12'h054
`define ESCL_REG_PRODUCT 12'h058
`define ESCL_REG_RESET_BASE 12'h060
`define ESCL_REG_NV_PTR 12'h064
`define ESCL_REG_NV_DATA 12'h068
`define ESCL_REG_LIVE_BASE 12'h400
`endif

// ===== design/escl_pkg.sv
// Purpose: types of the startup configuration loader
// Assumes: nothing beyond the defines header
// Notes: loader state machine and host interface codes
package escl_pkg;
  // loader sequence states
  typedef enum logic [2:0] {
    ESCL_CFG_READ,
    ESCL_RESET_COPY,
    ESCL_IDLE,
    ESCL_PROT_COPY,
    ESCL_NV_WRITE
  } escl_state_t;
  // host interface choice
  typedef enum logic [2:0] {
    ESCL_HOST_UART = 3'h0,
    ESCL_HOST_I2C = 3'h1,
    ESCL_HOST_SPI = 3'h2,
    ESCL_HOST_I2C_ALT = 3'h3,
    ESCL_HOST_PINS = 3'h4
  } escl_host_t;
endpackage

// ===== verification/escl_nv_model.sv
// Purpose: behavioural non-volatile byte array facing the loader
// Assumes: read data in the cycle that nv_rd_en stands, byte writes on nv_wr_en
// Notes: between reads the data line toggles so stale bytes never pass
`timescale 1ns/1ps
`default_nettype none
module escl_nv_model #(
  parameter logic [23:0] PID = 24'h6b6b6b, // arbitrary product code
  parameter logic [7:0] VER = 8'h0c, // arbitrary version code
  parameter int NV_AW = 13
) (
  input wire logic pclk,
  input wire logic [NV_AW-1:0] nv_addr,
  input wire logic nv_rd_en,
  input wire logic nv_wr_en,
  input wire logic [7:0] nv_wdata,
  output var logic [7:0] nv_rdata
);
  logic [7:0] mem [8192]; // whole array, contents kept across resets
  logic [7:0] idle_pat = 8'h00; // shown while no read is asked for
  // preset image; production bytes hold filler
  initial begin
    for (int a = 0; a < 8192; a++) begin
      mem[a] = 8'(a) ^ 8'h5a;
    end
    {mem[0], mem[1], mem[2], mem[3]} = {PID, VER};
    {mem[32], mem[33], mem[34]} = {8'h2a, 8'h91, 8'h33};
    {mem[64], mem[66], mem[67]} = {8'h40, 8'h80, 8'h05};
  end
  // the loader takes read data in the cycle that nv_rd_en stands
  assign nv_rdata = nv_rd_en ? mem[nv_addr] : idle_pat;
  // every byte is writable here, so only the loader guards the zones
  always @(posedge pclk) begin
    idle_pat <= ~idle_pat;
    if (nv_wr_en) begin
      mem[nv_addr] <= nv_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== verification/escl_loader_sva.sv
// Purpose: port-level checks of the startup configuration loader
// Assumes: one clock domain, async active-low reset
// Notes: attached by bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module escl_loader_sva #(
  parameter int NV_AW = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NV_AW-1:0] nv_addr,
  input wire logic nv_rd_en,
  input wire logic nv_wr_en,
  input wire logic [2:0] host_iface_sel,
  input wire logic [6:0] i2c_slave_addr,
  input wire logic [6:0] secure_module_addr,
  input wire logic bscan_en,
  input wire logic host_iface_en,
  input wire logic load_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_load_refuses_write: assert property (
    psel && penable && pwrite && !pready && !load_done |=> pslverr)
    else $error("write taken during copy");
  a_host_after_load: assert property ($rose(host_iface_en) |-> load_done)
    else $error("host enabled early");
  a_host_stays_on: assert property (host_iface_en |=> host_iface_en)
    else $error("host dropped");
  a_ro_write_blocked: assert property (
    nv_wr_en |-> nv_addr > 31 && nv_addr < 13'h1c00) else $error("ro nv write");
  a_nv_spacing: assert property (nv_rd_en |=> !nv_rd_en && !nv_wr_en)
    else $error("nv access too close");
  a_cfg_steady: assert property (load_done && $past(load_done) |->
    $stable(host_iface_sel) && $stable(i2c_slave_addr) && $stable(secure_module_addr)
    && $stable(bscan_en)) else $error("config moved while idle");
  c_proto_load: cover property ($fell(load_done) && host_iface_en);
  c_nv_write: cover property (nv_wr_en);
  c_refused: cover property (pslverr);
endmodule
`default_nettype wire

// ===== verification/test_escl_loader.sv
// Purpose: self-checking bench of the startup configuration loader
// Assumes: apb slave answers with one wait state, nv model behind it
// Notes: config bytes are rewritten in nv, then a reset reloads them
`timescale 1ns/1ps
`default_nettype none
`include "escl_defines.svh"
module test_escl_loader;
  localparam logic [23:0] PID = 24'h6b6b6b; // arbitrary product code
  localparam logic [7:0] VER = 8'h0c; // arbitrary version code
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_rd_en, nv_wr_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] nv_addr;
  logic [7:0] nv_wdata, nv_rdata;
  logic iface_pin_a, iface_pin_c, host_iface_en, i2c_speed_variant_sel, bscan_en, load_done;
  logic [1:0] host_pin_sel;
  logic [2:0] host_iface_sel;
  logic [6:0] i2c_slave_addr, secure_module_addr;
  // {iface byte, host, i2c address, speed, scan}
  logic [19:0] cfg [5] = '{{8'h00, 3'd0, 7'h56, 2'b01}, {8'h19, 3'd1, 7'h2a, 2'b00},
    {8'h82, 3'd2, 7'h56, 2'b11}, {8'h9b, 3'd3, 7'h2a, 2'b10}, {8'h8c, 3'd1, 7'h56, 2'b10}};
  int n_errors = 0;
  int n_compared = 0;
  escl_loader escl_loader_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nv_addr, .nv_rd_en, .nv_wr_en, .nv_wdata, .nv_rdata,
    .iface_pin_a, .iface_pin_c, .host_pin_sel, .host_iface_sel, .host_iface_en,
    .i2c_slave_addr, .i2c_speed_variant_sel, .bscan_en, .secure_module_addr, .load_done);
  escl_nv_model #(.PID(PID), .VER(VER), .NV_AW(13)) escl_nv_model_inst (.pclk, .nv_addr,
    .nv_rd_en, .nv_wr_en, .nv_wdata, .nv_rdata);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer; release only after the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      end_sim();
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // bounded wait for the loader to finish a copy
  task automatic wait_done;
    int i;
    for (i = 0; i < 2000 && load_done !== 1'b1; i++) @(negedge pclk);
    if (i >= 2000) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    do begin
      apb(0, `ESCL_REG_STATUS, 0);
      i++;
    end while (rd[3] !== 1'b0 && i < 40);
    if (i >= 40) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic rst;
    presetn <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
  endtask
  task automatic live(input logic [14:0] e);
    apb(0, 12'h400 + {3'h0, e[14:8], 2'b00}, 0);
    chk(rd, 32'(e[7:0]));
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {iface_pin_a, iface_pin_c, host_pin_sel} = 4'b0101;
    rst();
    apb(1, `ESCL_REG_I2C_ADDR, 0); chk(err, 1);
    wait_done();
    apb(0, `ESCL_REG_PRODUCT, 0); chk(rd, {PID, VER});
    chk(host_iface_en, 1);
    live({7'd0, 8'h40});
    live({7'd2, 8'h80});
    live({7'd3, 8'h05});
    live({7'd127, 8'he5});
    chk(secure_module_addr, 32'h33);
    foreach (cfg[k]) begin
      apb(1, `ESCL_REG_NV_PTR, 32'h21);
      wait_idle();
      apb(1, `ESCL_REG_NV_DATA, 32'(cfg[k][19:12])); chk(err, 0);
      wait_idle();
      rst();
      wait_done();
      apb(0, `ESCL_REG_IFACE, 0); chk(rd, 32'(cfg[k][19:12]));
      chk(host_iface_sel, 32'(cfg[k][11:9]));
      chk(i2c_slave_addr, 32'(cfg[k][8:2]));
      chk(i2c_speed_variant_sel, 32'(cfg[k][1]));
      chk(bscan_en, 32'(cfg[k][0]));
    end
    // a read-only byte must survive a write attempt
    apb(1, `ESCL_REG_NV_PTR, 32'h05);
    wait_idle();
    apb(1, `ESCL_REG_NV_DATA, 32'hff); chk(err, 1);
    wait_idle();
    chk(rd[4], 1);
    apb(1, `ESCL_REG_NV_PTR, 32'h05);
    wait_idle();
    apb(0, `ESCL_REG_NV_DATA, 0); chk(rd, 32'h5f);
    apb(0, 12'h300, 0); chk(err, 1);
    // load entry 1, then wait past the copy
    apb(1, `ESCL_REG_CTRL, 32'h0101);
    repeat (3) @(posedge pclk);
    wait_done();
    live({7'h40, 8'h42});
    live({7'h4f, 8'h7d});
    live({7'h50, 8'h72});
    live({7'h57, 8'h75});
    live({7'd0, 8'h40});
    // rerun the reset copy from a user base
    apb(1, `ESCL_REG_RESET_BASE, 32'h100);
    apb(0, `ESCL_REG_RESET_BASE, 0); chk(rd, 32'h100);
    apb(1, `ESCL_REG_CTRL, 32'h0004);
    repeat (3) @(posedge pclk);
    wait_done();
    live({7'd0, 8'h5a});
    live({7'd127, 8'h25});
    chk(host_iface_en, 1);
    end_sim();
  end
endmodule
bind escl_loader escl_loader_sva #(.NV_AW(NV_AW)) escl_loader_sva_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .pslverr, .nv_addr, .nv_rd_en, .nv_wr_en,
  .host_iface_sel, .i2c_slave_addr, .secure_module_addr, .bscan_en, .host_iface_en,
  .load_done);
`default_nettype wire
